// >>> rtl/ssr_top.sv
`default_nettype none
// Overview of operation
// - The comm-failure group holds 16-bit condition, rise filter, fall filter, event and enable registers and makes one summary.
// - Bit 15 of every comm-failure group register always reads zero.
// - Condition bit 1 follows the transmit analyzer channel failure and bit 0 the receive analyzer channel failure.
// - The event register clears when it is queried and when the clear status command arrives.
// - The enable register is cleared by reset or by any write with bits 1 and 0 zero, after which all enable bits stay low until the next write.
// - Both edge filters can be written with an integer and read back, alongside reads of condition, event and enable.
// - Eight register groups each reduce to one summary that reaches the status byte directly or via another group.
// - Status byte bit 7 is the operation summary, 5 the standard event bit, 4 message available, 3 questionable, 2 unused.
// - Status byte bit 1 carries the second hardware group summary and bit 0 the first.
// - Status byte bit 6 returns the request service flag on serial poll and the master summary flag on status byte query.
// - An enabled service condition asserts the service request line and sets the request service flag.
// - A serial poll clears the request service flag so a repeat poll reads false until a new reason occurs.
// - An event bit latches only on a condition change whose polarity the matching filter passes.
// - The group summary is true when any enabled event bit has been set since the last read or clear.
// - Writes to the service request enable register ignore bit 6.
module ssr_top (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Status command port
    input  wire logic        cmdValid,
    input  wire logic [3:0]  cmdCode,
    input  wire logic [15:0] cmdData,
    // Response port
    output logic             rspValid,
    output logic      [15:0] rspData,
    output logic             cmdReject,
    // Channel failure inputs
    input  wire logic        txChanFail,
    input  wire logic        rxChanFail,
    // Summaries from the other groups
    input  wire logic        operSummary,
    input  wire logic        stdEventSummaryBit,
    input  wire logic        outputMessageAvailable,
    input  wire logic        questSummary,
    input  wire logic        hw2Summary,
    input  wire logic        hw1Summary,
    // Summaries out
    output logic             commSummary,
    output logic             srqActive
);

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    function automatic logic isCmd(input logic v, input logic [3:0] c, input logic [3:0] k);
        isCmd = v && (c == k);
    endfunction

    logic        rdCond;
    logic        rdRise;
    logic        wrRise;
    logic        rdFall;
    logic        wrFall;
    logic        rdEvent;
    logic        rdEnable;
    logic        wrEnable;
    logic        clearStatus;
    logic        stbQuery;
    logic        rdSre;
    logic        wrSre;
    logic        serialPoll;
    logic        knownCmd;
    logic        evtClear;
    logic [15:0] commCondIn;
    logic [15:0] commCond;
    logic [15:0] commRise;
    logic [15:0] commFall;
    logic [15:0] commEvent;
    logic [15:0] commEnable;
    logic [7:0]  queryByte;
    logic [7:0]  pollByte;
    logic [7:0]  sreValue;
    logic        masterSummaryFlag;
    logic        requestServiceFlag;
    logic [15:0] rsp_next;

    assign rdCond      = isCmd(cmdValid, cmdCode, ssr_pkg::CMD_RD_COND);
    assign rdRise      = isCmd(cmdValid, cmdCode, ssr_pkg::CMD_RD_RISE);
    assign wrRise      = isCmd(cmdValid, cmdCode, ssr_pkg::CMD_WR_RISE);
    assign rdFall      = isCmd(cmdValid, cmdCode, ssr_pkg::CMD_RD_FALL);
    assign wrFall      = isCmd(cmdValid, cmdCode, ssr_pkg::CMD_WR_FALL);
    assign rdEvent     = isCmd(cmdValid, cmdCode, ssr_pkg::CMD_RD_EVENT);
    assign rdEnable    = isCmd(cmdValid, cmdCode, ssr_pkg::CMD_RD_ENABLE);
    assign wrEnable    = isCmd(cmdValid, cmdCode, ssr_pkg::CMD_WR_ENABLE);
    assign clearStatus = isCmd(cmdValid, cmdCode, ssr_pkg::CMD_CLS);
    assign stbQuery    = isCmd(cmdValid, cmdCode, ssr_pkg::CMD_STB_QUERY);
    assign rdSre       = isCmd(cmdValid, cmdCode, ssr_pkg::CMD_RD_SRE);
    assign wrSre       = isCmd(cmdValid, cmdCode, ssr_pkg::CMD_WR_SRE);
    assign serialPoll  = isCmd(cmdValid, cmdCode, ssr_pkg::CMD_POLL);
    assign knownCmd    = rdCond | rdRise | wrRise | rdFall | wrFall | rdEvent | rdEnable
                       | wrEnable | clearStatus | stbQuery | rdSre | wrSre | serialPoll;
    assign evtClear    = rdEvent | clearStatus;

    // ----------------------------------------
    // Comm-failure group
    // ----------------------------------------
    assign commCondIn = {14'h0000, txChanFail, rxChanFail};

    ssr_group #(
        .W        (ssr_pkg::GRP_W),
        .USED     (ssr_pkg::COMM_USED_MASK)
    ) u_comm (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .condIn   (commCondIn),
        .wrRise   (wrRise),
        .wrFall   (wrFall),
        .wrEnable (wrEnable),
        .wrData   (cmdData),
        .clrEvent (evtClear),
        .condOut  (commCond),
        .riseOut  (commRise),
        .fallOut  (commFall),
        .eventOut (commEvent),
        .enableOut(commEnable),
        .summary  (commSummary)
    );

    // ----------------------------------------
    // Status byte and service request
    // ----------------------------------------
    ssr_stb u_stb (
        .ref_clk               (ref_clk),
        .rst_n                 (rst_n),
        .operSummary           (operSummary),
        .stdEventSummaryBit    (stdEventSummaryBit),
        .outputMessageAvailable(outputMessageAvailable),
        .questSummary          (questSummary),
        .hw2Summary            (hw2Summary),
        .hw1Summary            (hw1Summary),
        .wrSre                 (wrSre),
        .sreData               (cmdData[7:0]),
        .serialPoll            (serialPoll),
        .queryByte             (queryByte),
        .pollByte              (pollByte),
        .sreOut                (sreValue),
        .masterSummaryFlag     (masterSummaryFlag),
        .requestServiceFlag    (requestServiceFlag)
    );

    assign srqActive = requestServiceFlag;

    // ----------------------------------------
    // Response selection
    // ----------------------------------------
    assign rsp_next = rdCond   ? commCond   :
                      rdRise   ? commRise   :
                      rdFall   ? commFall   :
                      rdEvent  ? commEvent  :
                      rdEnable ? commEnable :
                      stbQuery ? {8'h00, queryByte} :
                      serialPoll ? {8'h00, pollByte} :
                      rdSre    ? {8'h00, sreValue} : 16'h0000;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rspValid  <= 1'b0;
            rspData   <= 16'h0000;
            cmdReject <= 1'b0;
        end
        else
        begin
            rspValid  <= rdCond | rdRise | rdFall | rdEvent | rdEnable
                       | stbQuery | serialPoll | rdSre;
            rspData   <= rsp_next;
            cmdReject <= cmdValid & ~knownCmd;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic [15:0] condPast_reg;
    logic [15:0] expectEdges;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            condPast_reg <= 16'h0000;
        else
            condPast_reg <= commCond;
    end

    assign expectEdges = ((commCond & ~condPast_reg & commRise)
                        | (~commCond & condPast_reg & commFall));

    sequence evtClearQuiet;
        evtClear && (commCond == $past(commCond));
    endsequence

    sequence pollNoReason;
        serialPoll && requestServiceFlag && !masterSummaryFlag;
    endsequence

    sequence reasonRise;
        masterSummaryFlag && !$past(masterSummaryFlag);
    endsequence

    a_top_bit_zero: assert property (
        !(commCond[15] | commRise[15] | commFall[15] | commEvent[15] | commEnable[15]))
        else $error("comm group bit 15 not zero");

    a_unused_bits_zero: assert property (
        ((commCond | commRise | commFall | commEvent | commEnable) & 16'hfffc) == 16'h0000
        && !queryByte[ssr_pkg::STB_UNUSED] && !pollByte[ssr_pkg::STB_UNUSED])
        else $error("unused bits not zero");

    a_cond_follows_chan: assert property (
        ##1 (commCond[1] == $past(txChanFail)) && (commCond[0] == $past(rxChanFail)))
        else $error("condition does not follow channel failures");

    a_event_clear_read: assert property (
        evtClearQuiet |=> commEvent == 16'h0000)
        else $error("event register not cleared");

    a_enable_zero_write: assert property (
        wrEnable && cmdData == 16'h0000 |=> commEnable == 16'h0000 && !commSummary)
        else $error("enable not cleared by zero write");

    a_filter_readback: assert property (
        wrRise ##1 rdRise |=> rspValid && rspData == ($past(cmdData, 2) & 16'h0003))
        else $error("rise filter readback wrong");

    a_edge_latch_only: assert property (
        ##1 ((commEvent & ~$past(commEvent)) & ~$past(expectEdges)) == 16'h0000)
        else $error("event latched without a passed edge");

    a_summary_follows: assert property (
        commSummary == |(commEvent & commEnable))
        else $error("group summary mismatch");

    a_stb_mapping: assert property (
        stbQuery |=> rspData[7] == $past(operSummary) && rspData[5] == $past(stdEventSummaryBit)
        && rspData[4] == $past(outputMessageAvailable) && rspData[3] == $past(questSummary)
        && rspData[1] == $past(hw2Summary) && rspData[0] == $past(hw1Summary))
        else $error("status byte mapping wrong");

    a_bit6_source: assert property (
        (serialPoll |=> rspData[6] == $past(requestServiceFlag))
        and (stbQuery |=> rspData[6] == $past(masterSummaryFlag)))
        else $error("status byte bit 6 source wrong");

    a_srq_on_reason: assert property (
        reasonRise |=> requestServiceFlag && srqActive)
        else $error("service request not raised");

    a_poll_clears_rqs: assert property (
        pollNoReason |=> !requestServiceFlag ##1 (!requestServiceFlag
        || ($past(masterSummaryFlag) && !$past(masterSummaryFlag, 2))))
        else $error("serial poll did not clear request flag");

    a_sre_bit6_ignored: assert property (
        wrSre |=> !sreValue[ssr_pkg::STB_RQS] && sreValue == ($past(cmdData[7:0]) & 8'hbf))
        else $error("service enable bit 6 not ignored");

    a_no_enable_no_srq: assert property (
        sreValue == 8'h00 |-> !masterSummaryFlag)
        else $error("summary without any enable");

    sequence readCmd;
        rdCond || rdRise || rdFall || rdEvent
        || rdEnable || stbQuery || serialPoll || rdSre;
    endsequence

    a_read_answers: assert property (
        readCmd |=> rspValid && !cmdReject)
        else $error("read command without response");

    a_write_silent: assert property (
        (wrRise || wrFall || wrEnable || wrSre || clearStatus) |=> !rspValid && !cmdReject)
        else $error("write command produced a response");

    a_reject_no_change: assert property (
        cmdValid && !knownCmd |=> cmdReject && !rspValid && $stable(commRise)
        && $stable(commFall) && $stable(commEnable) && $stable(sreValue))
        else $error("unknown command changed state");

    a_enable_holds: assert property (
        !wrEnable |=> $stable(commEnable))
        else $error("enable changed without a write");

    a_rise_write: assert property (
        wrRise |=> commRise == ($past(cmdData) & ssr_pkg::COMM_USED_MASK))
        else $error("rise filter write wrong");

    a_event_read_data: assert property (
        rdEvent |=> rspData == $past(commEvent))
        else $error("event read data wrong");

    a_event_holds: assert property (
        !evtClear && expectEdges == 16'h0000 |=> commEvent == $past(commEvent))
        else $error("event changed without an edge or clear");

endmodule
`default_nettype wire

// >>> rtl/ssr_pkg.sv
`default_nettype none
package ssr_pkg;

    // ----------------------------------------
    // Register group layout
    // ----------------------------------------
    localparam int          GRP_W          = 16;
    localparam logic [15:0] COMM_USED_MASK = 16'h0003;
    localparam int          COMM_TX_BIT    = 1;
    localparam int          COMM_RX_BIT    = 0;
    localparam int          GRP_TOP_BIT    = 15;
    localparam logic [15:0] GRP_RESET      = 16'h0000;
    localparam int          NUM_GROUPS     = 8;

    // ----------------------------------------
    // Status byte layout
    // ----------------------------------------
    localparam int         STB_W          = 8;
    localparam int         STB_OPER       = 7;
    localparam int         STB_RQS        = 6;
    localparam int         STB_ESB        = 5;
    localparam int         STB_MAV        = 4;
    localparam int         STB_QUES       = 3;
    localparam int         STB_UNUSED     = 2;
    localparam int         STB_HW2        = 1;
    localparam int         STB_HW1        = 0;
    localparam logic [7:0] SRE_RESET      = 8'h00;
    localparam logic [7:0] SRE_WRITE_MASK = 8'hbf;

    // ----------------------------------------
    // Status command codes
    // ----------------------------------------
    localparam logic [3:0] CMD_RD_COND   = 4'h1;
    localparam logic [3:0] CMD_RD_RISE   = 4'h2;
    localparam logic [3:0] CMD_WR_RISE   = 4'h3;
    localparam logic [3:0] CMD_RD_FALL   = 4'h4;
    localparam logic [3:0] CMD_WR_FALL   = 4'h5;
    localparam logic [3:0] CMD_RD_EVENT  = 4'h6;
    localparam logic [3:0] CMD_RD_ENABLE = 4'h7;
    localparam logic [3:0] CMD_WR_ENABLE = 4'h8;
    localparam logic [3:0] CMD_CLS       = 4'h9;
    localparam logic [3:0] CMD_STB_QUERY = 4'ha;
    localparam logic [3:0] CMD_RD_SRE    = 4'hb;
    localparam logic [3:0] CMD_WR_SRE    = 4'hc;
    localparam logic [3:0] CMD_POLL      = 4'hd;

    // Cycles from command to response
    localparam int RSP_LATENCY = 1;

endpackage
`default_nettype wire

// >>> rtl/ssr_group.sv
`default_nettype none
module ssr_group #(
    parameter int               W    = 16,
    parameter logic [W-1:0]     USED = ssr_pkg::COMM_USED_MASK
) (
    // Clock and reset
    input  wire logic           ref_clk,
    input  wire logic           rst_n,
    // Condition inputs
    input  wire logic [W-1:0]   condIn,
    // Register writes and clear
    input  wire logic           wrRise,
    input  wire logic           wrFall,
    input  wire logic           wrEnable,
    input  wire logic [W-1:0]   wrData,
    input  wire logic           clrEvent,
    // Register contents
    output logic      [W-1:0]   condOut,
    output logic      [W-1:0]   riseOut,
    output logic      [W-1:0]   fallOut,
    output logic      [W-1:0]   eventOut,
    output logic      [W-1:0]   enableOut,
    output logic                summary
);

    logic [W-1:0] condPrev_reg;
    logic [W-1:0] passedEdges;
    logic [W-1:0] event_next;

    // ----------------------------------------
    // Edge filtering and event latch
    // ----------------------------------------
    assign passedEdges = ((condOut & ~condPrev_reg & riseOut)
                        | (~condOut & condPrev_reg & fallOut)) & USED;
    assign event_next  = (clrEvent ? '0 : eventOut) | passedEdges;
    assign summary     = |(eventOut & enableOut);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            condOut      <= '0;
            condPrev_reg <= '0;
            riseOut      <= '0;
            fallOut      <= '0;
            eventOut     <= '0;
            enableOut    <= '0;
        end
        else
        begin
            condOut      <= condIn & USED;
            condPrev_reg <= condOut;
            eventOut     <= event_next;
            if (wrRise)
                riseOut <= wrData & USED;
            if (wrFall)
                fallOut <= wrData & USED;
            if (wrEnable)
                enableOut <= wrData & USED;
        end
    end

endmodule
`default_nettype wire

// >>> rtl/ssr_stb.sv
`default_nettype none
module ssr_stb (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Group summaries
    input  wire logic        operSummary,
    input  wire logic        stdEventSummaryBit,
    input  wire logic        outputMessageAvailable,
    input  wire logic        questSummary,
    input  wire logic        hw2Summary,
    input  wire logic        hw1Summary,
    // Enable write and poll
    input  wire logic        wrSre,
    input  wire logic [7:0]  sreData,
    input  wire logic        serialPoll,
    // Status
    output logic      [7:0]  queryByte,
    output logic      [7:0]  pollByte,
    output logic      [7:0]  sreOut,
    output logic             masterSummaryFlag,
    output logic             requestServiceFlag
);

    logic [7:0] summaries;
    logic       mssPrev_reg;
    logic       newReason;

    // ----------------------------------------
    // Status byte assembly
    // ----------------------------------------
    assign summaries = {operSummary, 1'b0, stdEventSummaryBit, outputMessageAvailable,
                        questSummary, 1'b0, hw2Summary, hw1Summary};
    assign masterSummaryFlag = |(summaries & sreOut);
    assign newReason = masterSummaryFlag & ~mssPrev_reg;
    assign queryByte = {summaries[7], masterSummaryFlag, summaries[5:0]};
    assign pollByte  = {summaries[7], requestServiceFlag, summaries[5:0]};

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sreOut             <= ssr_pkg::SRE_RESET;
            mssPrev_reg        <= 1'b0;
            requestServiceFlag <= 1'b0;
        end
        else
        begin
            if (wrSre)
                sreOut <= sreData & ssr_pkg::SRE_WRITE_MASK;
            mssPrev_reg <= masterSummaryFlag;
            if (newReason)
                requestServiceFlag <= 1'b1;
            else if (serialPoll)
                requestServiceFlag <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// >>> bench/ssr_ctrl_model.sv
`default_nettype none
module ssr_ctrl_model (
    // Clock
    input  wire logic        ref_clk,
    // Command side
    output logic             cmdValid,
    output logic      [3:0]  cmdCode,
    output logic      [15:0] cmdData,
    // Response side
    input  wire logic        rspValid,
    input  wire logic [15:0] rspData,
    input  wire logic        cmdReject
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        cmdValid = 1'b0;
        cmdCode  = 4'h0;
        cmdData  = 16'h0000;
    end

    // ----------------------------------------
    // One command, answer taken one edge later
    // ----------------------------------------
    task automatic xfer(input logic [3:0] code, input logic [15:0] data,
                        output logic vld, output logic [15:0] rsp, output logic rej);
        @(negedge ref_clk);
        cmdValid = 1'b1;
        cmdCode  = code;
        cmdData  = data;
        @(negedge ref_clk);
        cmdValid = 1'b0;
        // Released qualifiers must not keep the last value
        cmdCode  = ~code;
        cmdData  = ~data;
        vld      = rspValid;
        rsp      = rspData;
        rej      = cmdReject;
    endtask

    // ----------------------------------------
    // Two commands on consecutive edges
    // ----------------------------------------
    task automatic pair(input logic [3:0] code1, input logic [15:0] data1,
                        input logic [3:0] code2, input logic [15:0] data2,
                        output logic vld, output logic [15:0] rsp, output logic rej);
        @(negedge ref_clk);
        cmdValid = 1'b1;
        cmdCode  = code1;
        cmdData  = data1;
        @(negedge ref_clk);
        cmdCode  = code2;
        cmdData  = data2;
        @(negedge ref_clk);
        cmdValid = 1'b0;
        cmdCode  = ~code2;
        cmdData  = ~data2;
        vld      = rspValid;
        rsp      = rspData;
        rej      = cmdReject;
    endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end

    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        cmdValid, rspValid, cmdReject, commSummary, srqActive;
    logic [3:0]  cmdCode;
    logic [15:0] cmdData, rspData;
    logic        txChanFail = 1'b0, rxChanFail = 1'b0;
    logic [5:0]  sums = 6'h00;
    int          mismatches = 0, comparisons = 0, cycles = 0;

    always #2.5 ref_clk = ~ref_clk;

    ssr_ctrl_model ctrl (.ref_clk(ref_clk), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData), .cmdReject(cmdReject));

    ssr_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData), .cmdReject(cmdReject),
        .txChanFail(txChanFail), .rxChanFail(rxChanFail), .operSummary(sums[5]),
        .stdEventSummaryBit(sums[4]), .outputMessageAvailable(sums[3]),
        .questSummary(sums[2]), .hw2Summary(sums[1]), .hw1Summary(sums[0]),
        .commSummary(commSummary), .srqActive(srqActive));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic final_report();
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            final_report();
        end
    end

    task automatic waitc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic wr(input logic [3:0] code, input logic [15:0] data);
        logic        v, j;
        logic [15:0] r;
        ctrl.xfer(code, data, v, r, j);
        `CHK({v, j}, 2'b00)
    endtask

    task automatic rd(input logic [3:0] code, input logic [15:0] exp);
        logic        v, j;
        logic [15:0] r;
        ctrl.xfer(code, 16'h0000, v, r, j);
        `CHK({v, j}, 2'b10)
        `CHK(r, exp)
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [3:0] codes [6];
        codes = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'hb};
        foreach (codes[i])
            rd(codes[i], 16'h0000);
    endtask

    task automatic t_filters();
        wr(ssr_pkg::CMD_WR_RISE, 16'hffff);
        rd(ssr_pkg::CMD_RD_RISE, 16'h0003);
        wr(ssr_pkg::CMD_WR_FALL, 16'h8006);
        rd(ssr_pkg::CMD_RD_FALL, 16'h0002);
    endtask

    task automatic t_events();
        wr(ssr_pkg::CMD_WR_RISE, 16'h0003);
        wr(ssr_pkg::CMD_WR_FALL, 16'h0000);
        txChanFail = 1'b1;
        waitc(3);
        rd(ssr_pkg::CMD_RD_COND, 16'h0002);
        rd(ssr_pkg::CMD_RD_EVENT, 16'h0002);
        rd(ssr_pkg::CMD_RD_EVENT, 16'h0000);
        txChanFail = 1'b0;
        waitc(3);
        rd(ssr_pkg::CMD_RD_EVENT, 16'h0000);
        wr(ssr_pkg::CMD_WR_RISE, 16'h0000);
        wr(ssr_pkg::CMD_WR_FALL, 16'h0003);
        rxChanFail = 1'b1;
        waitc(3);
        rd(ssr_pkg::CMD_RD_COND, 16'h0001);
        rd(ssr_pkg::CMD_RD_EVENT, 16'h0000);
        rxChanFail = 1'b0;
        waitc(3);
        rd(ssr_pkg::CMD_RD_EVENT, 16'h0001);
        txChanFail = 1'b1;
        waitc(3);
        txChanFail = 1'b0;
        waitc(3);
        wr(ssr_pkg::CMD_CLS, 16'h0000);
        rd(ssr_pkg::CMD_RD_EVENT, 16'h0000);
    endtask

    task automatic t_summary();
        wr(ssr_pkg::CMD_WR_FALL, 16'h0000);
        wr(ssr_pkg::CMD_WR_ENABLE, 16'hffff);
        rd(ssr_pkg::CMD_RD_ENABLE, 16'h0003);
        `CHK(commSummary, 1'b0)
        wr(ssr_pkg::CMD_WR_RISE, 16'h0003);
        txChanFail = 1'b1;
        waitc(3);
        `CHK(commSummary, 1'b1)
        wr(ssr_pkg::CMD_WR_ENABLE, 16'h0000);
        `CHK(commSummary, 1'b0)
        rd(ssr_pkg::CMD_RD_ENABLE, 16'h0000);
        wr(ssr_pkg::CMD_WR_ENABLE, 16'h0002);
        `CHK(commSummary, 1'b1)
        rd(ssr_pkg::CMD_RD_EVENT, 16'h0002);
        `CHK(commSummary, 1'b0)
        txChanFail = 1'b0;
        wr(ssr_pkg::CMD_WR_ENABLE, 16'h0000);
    endtask

    task automatic t_stb();
        sums = 6'h2b;
        wr(ssr_pkg::CMD_WR_SRE, 16'h0000);
        waitc(2);
        rd(ssr_pkg::CMD_STB_QUERY, 16'h0093);
        `CHK(srqActive, 1'b0)
        wr(ssr_pkg::CMD_WR_SRE, 16'h00ff);
        waitc(2);
        rd(ssr_pkg::CMD_RD_SRE, 16'h00bf);
        `CHK(srqActive, 1'b1)
        rd(ssr_pkg::CMD_POLL, 16'h00d3);
        `CHK(srqActive, 1'b0)
        rd(ssr_pkg::CMD_POLL, 16'h0093);
        rd(ssr_pkg::CMD_STB_QUERY, 16'h00d3);
        sums = 6'h00;
        waitc(2);
        sums = 6'h10;
        waitc(2);
        `CHK(srqActive, 1'b1)
        rd(ssr_pkg::CMD_POLL, 16'h0060);
        sums = 6'h00;
        waitc(2);
        sums = 6'h10;
        waitc(2);
        sums = 6'h00;
        waitc(1);
        rd(ssr_pkg::CMD_POLL, 16'h0040);
        rd(ssr_pkg::CMD_POLL, 16'h0000);
        wr(ssr_pkg::CMD_WR_SRE, 16'h0000);
    endtask

    task automatic t_b2b();
        logic        v, j;
        logic [15:0] r;
        ctrl.pair(ssr_pkg::CMD_WR_RISE, 16'h0001, ssr_pkg::CMD_RD_RISE, 16'h0000, v, r, j);
        `CHK({v, j}, 2'b10)
        `CHK(r, 16'h0001)
        ctrl.pair(ssr_pkg::CMD_WR_ENABLE, 16'h0002, ssr_pkg::CMD_RD_ENABLE, 16'h0000, v, r, j);
        `CHK(r, 16'h0002)
        wr(ssr_pkg::CMD_WR_ENABLE, 16'h0000);
        rd(ssr_pkg::CMD_RD_ENABLE, 16'h0000);
    endtask

    task automatic t_reject();
        logic [3:0]  codes [3];
        logic        v, j;
        logic [15:0] r;
        codes = '{4'h0, 4'he, 4'hf};
        foreach (codes[i])
        begin
            ctrl.xfer(codes[i], 16'hffff, v, r, j);
            `CHK({v, j}, 2'b01)
        end
        rd(ssr_pkg::CMD_RD_ENABLE, 16'h0000);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        waitc(16);
        `CHK({rspValid, cmdReject, srqActive, commSummary}, 4'h0)
        rst_n = 1'b1;
        t_reset();
        t_filters();
        t_events();
        t_summary();
        t_stb();
        t_reject();
        t_b2b();
        final_report();
    end
endmodule
`default_nettype wire
